// file: bci_defs.svh
// Offsets, field positions, reset values and step times of the board control
`ifndef BCI_DEFS_SVH
`define BCI_DEFS_SVH

// Board control register location in the local register space
`define BCI_BOARD_CTRL_OFS 5'h00
`define BCI_RESET_VAL 32'h041387C1
// Bits that are stored plainly on a write (modes, sizes, enables, selects)
`define BCI_PLAIN_MASK 32'h038FFFDF

// Field positions
`define BCI_MODE_MSB 2
`define BCI_MODE_LSB 0
`define BCI_LOOP_MSB 4
`define BCI_LOOP_LSB 3
`define BCI_CALFAIL 5
`define BCI_OFSBIN 6
`define BCI_DEPTH_MSB 10
`define BCI_DEPTH_LSB 7
`define BCI_BUFCLR 11
`define BCI_CHCNT_MSB 17
`define BCI_CHCNT_LSB 15
`define BCI_OUTEN 18
`define BCI_STBEN 19
`define BCI_EMPTY 20
`define BCI_HALF 21
`define BCI_FULL 22
`define BCI_IRQSEL_MSB 25
`define BCI_IRQSEL_LSB 23
`define BCI_IRQFLAG 26
`define BCI_CALM_MSB 28
`define BCI_CALM_LSB 27
`define BCI_STROBE 29
`define BCI_TRIG 30
`define BCI_INIT 31

// Input mode codes
`define BCI_MODE_SE_CONT 3'h0
`define BCI_MODE_SE_BURST 3'h1
`define BCI_MODE_DI_CONT 3'h2
`define BCI_MODE_DI_BURST 3'h3
`define BCI_MODE_LOOP 3'h4
`define BCI_MODE_VREF 3'h5
`define BCI_MODE_RSVD 3'h6
`define BCI_MODE_ZERO 3'h7

// Step times and clock rate
`define BCI_CLK_KHZ 200000
`define BCI_BUS_CFG_MS 3
`define BCI_LOGIC_CFG_MS 300
`define BCI_INIT_MS 3

`endif

// file: bci_pkg.sv
// Types shared by the board control and init sequencer
package bci_pkg;

  // Power-up and reinit sequencer states
  typedef enum logic [2:0] {
    BCI_ST_CFG_LOAD = 3'b000,
    BCI_ST_LOGIC_CFG = 3'b001,
    BCI_ST_INIT = 3'b010,
    BCI_ST_READY = 3'b011
  } bci_state_t;

  // Step code shown to the ROM loader
  typedef enum logic [1:0] {
    BCI_STEP_BUS_CFG = 2'b00,
    BCI_STEP_LOGIC_CFG = 2'b01,
    BCI_STEP_INIT = 2'b10
  } bci_step_t;

endpackage

// file: bci_step_timer.sv
// Down counter that bounds the length of one sequencer step
`timescale 1ns/10ps
module bci_step_timer
  import bci_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic start, // Load and run
  input wire logic [31:0] load_val, // Cycles until expiry
  output logic expired_q // One-cycle expiry pulse
);

  logic [31:0] count_q;
  logic run_q;

  // A new start always wins, so a stale count never leaks into a new step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 32'h0000_0000;
      run_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (start) begin
        count_q <= load_val;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (count_q <= 32'h0000_0001) begin
          expired_q <= 1'b1;
          run_q <= 1'b0;
        end else begin
          count_q <= count_q - 32'h0000_0001;
        end
      end
    end
  end

endmodule

// file: bci_board_ctrl.sv
// Board control register and power-up / reinit sequencer
`timescale 1ns/10ps
`include "bci_defs.svh"

// Behaviour
// [R01] Mode field bits 2:0 picks input wiring or selftest; resets single-ended burst.
// [R02] Bits 4:3 pick loopback output channel; reset to channel zero.
// [R03] Bit 5 read-only calibration fail flag; low after init.
// [R04] Bit 6 selects offset binary when set; resets set.
// [R05] Bits 10:7 set input buffer depth; reset all ones.
// [R06] Bit 11 empties and holds buffer disabled; software clears it; resets low.
// [R07] Bits 17:15 give active channels minus one; reset seven.
// [R08] Bit 18 connects analog outputs; reset disconnected.
// [R09] Bit 19 makes outputs update only on strobe; reset disabled.
// [R10] Bits 20 to 22 show buffer empty, half, full; empty after init.
// [R11] Bits 25:23 select interrupt source; reset zero.
// [R12] Device sets bit 26 on interrupt; host clears it by writing low.
// [R13] Bits 28:27 calibration mode; normal default; clear when calibration completes.
// [R14] Writing bit 29 strobes outputs; clears itself when strobe finishes.
// [R15] Bit 30 starts one conversion, only in burst modes; self-clears.
// [R16] Five upper command bits return to zero by hardware when done.
// [R17] After bus reset: bus config 3 ms, logic config 300 ms, init 3 ms.
// [R18] Power-up configuration ends with bus interrupts disabled.
// [R19] Host waits for interrupts enabled and init-complete request before access.
// [R20] Bit 31 reinitializes logic only, within 3 ms, then self-clears.
// [R21] Reinit loads calibration, empties buffer, raises request, restores defaults.
// [R22] Bus accesses answered with retry until bus config is loaded.
// [R23] Whole register takes 0x041387C1 on initialization.
// [R24] Register sits at offset zero, 32-bit read and write.
// [R25] Mode codes: 0,1 single-ended, 2,3 differential, 4,5,7 tests, 6 reserved.
module bci_board_ctrl
  import bci_pkg::*;
#(
  parameter int unsigned BUS_CFG_CYC = `BCI_BUS_CFG_MS * `BCI_CLK_KHZ,
  parameter int unsigned LOGIC_CFG_CYC = `BCI_LOGIC_CFG_MS * `BCI_CLK_KHZ,
  parameter int unsigned INIT_CYC = `BCI_INIT_MS * `BCI_CLK_KHZ
)
(
  input wire logic clk, // 200 MHz system clock
  input wire logic sys_rst, // Async reset, high
  input wire logic host_rst_in, // Host bus reset pin, high
  input wire logic bus_req, // Local register access strobe
  input wire logic bus_wr, // Write when high
  input wire logic [4:0] bus_addr, // Byte offset
  input wire logic [31:0] bus_wdata, // Write data
  output logic [31:0] bus_rdata_q, // Read data
  output logic bus_ack_q, // Access done
  output logic bus_retry_q, // Access must be retried
  input wire logic bus_irq_en_set, // Host enables bus interrupts
  input wire logic bus_irq_en_clr, // Host disables bus interrupts
  input wire logic [7:0] irq_cond, // Interrupt condition events
  input wire logic cal_done, // Calibration finished
  input wire logic cal_fail, // Result with cal_done
  input wire logic strobe_done, // Output strobe finished
  input wire logic conv_done, // Burst conversion finished
  input wire logic step_done, // ROM loader finished a step
  input wire logic buf_empty, // Input buffer empty
  input wire logic buf_half, // Input buffer half full
  input wire logic buf_full, // Input buffer full
  output logic [2:0] input_mode_sel_q, // Input mode
  output logic [1:0] loopback_chan_q, // Loopback channel
  output logic offset_binary_q, // Data coding
  output logic [3:0] buffer_depth_q, // Buffer depth code
  output logic buf_flush_q, // Empty and disable buffer
  output logic [2:0] active_chan_count_q, // Channels minus one
  output logic out_enable_q, // Outputs to connector
  output logic out_strobe_en_q, // Strobed output update
  output logic [2:0] irq_source_sel_q, // Interrupt source
  output logic [1:0] calib_mode_q, // Calibration mode
  output logic burst_mode_q, // Burst mode active
  output logic strobe_go_q, // Software strobe pulse
  output logic conv_go_q, // Conversion start pulse
  output logic [1:0] rom_step_q, // Current ROM step
  output logic rom_go_q, // Step start pulse
  output logic init_busy_q, // Sequencer not ready
  output logic bus_irq_en_q, // Bus interrupts enabled
  output logic irq_req_q // Interrupt request
);

  // Burst modes take software triggers
  function automatic logic is_burst(input logic [2:0] m);
    is_burst = (m == `BCI_MODE_SE_BURST) || (m == `BCI_MODE_DI_BURST) ||
               (m == `BCI_MODE_LOOP) || (m == `BCI_MODE_VREF) ||
               (m == `BCI_MODE_ZERO); // see [R25]
  endfunction

  logic hr_s1_q;
  logic hr_s2_q;
  bci_state_t state_q;
  bci_state_t state_d;
  logic armed_q;
  logic step_start;
  logic adv;
  logic tmr_exp;
  logic [31:0] tmr_load;
  logic [31:0] ctrl_q;
  logic [31:0] rd_val;
  logic reg_hit;
  logic wr_hit;
  logic init_wr;
  logic irq_set;

  // Host reset arrives from outside the clock domain
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hr_s1_q <= 1'b0;
      hr_s2_q <= 1'b0;
    end else begin
      hr_s1_q <= host_rst_in;
      hr_s2_q <= hr_s1_q;
    end
  end

  // Access decode
  assign reg_hit = bus_req && (bus_addr == `BCI_BOARD_CTRL_OFS); // see [R24]
  assign wr_hit = reg_hit && bus_wr && (state_q == BCI_ST_READY);
  assign init_wr = wr_hit && bus_wdata[`BCI_INIT]; // see [R20]
  assign irq_set = irq_cond[ctrl_q[`BCI_IRQSEL_MSB:`BCI_IRQSEL_LSB]]; // see [R11]
  assign adv = armed_q && (step_done || tmr_exp);

  // Sequencer: each step ends on loader done or at its longest time
  always_comb begin
    state_d = state_q;
    step_start = 1'b0;
    case (state_q)
      BCI_ST_CFG_LOAD: begin
        if (!armed_q) begin
          step_start = 1'b1;
        end else if (adv) begin
          state_d = BCI_ST_LOGIC_CFG; // see [R17]
          step_start = 1'b1;
        end
      end
      BCI_ST_LOGIC_CFG: begin
        if (adv) begin
          state_d = BCI_ST_INIT; // see [R17]
          step_start = 1'b1;
        end
      end
      BCI_ST_INIT: begin
        if (adv) begin
          state_d = BCI_ST_READY;
        end
      end
      BCI_ST_READY: begin
        if (init_wr) begin
          state_d = BCI_ST_INIT; // see [R20]
          step_start = 1'b1;
        end
      end
      default: begin
        state_d = BCI_ST_CFG_LOAD;
      end
    endcase
    // Bus reset holds the whole sequence at its first step
    if (hr_s2_q) begin
      state_d = BCI_ST_CFG_LOAD;
      step_start = 1'b0;
    end
  end

  // Step time limit for the step being entered
  always_comb begin
    case (state_d)
      BCI_ST_LOGIC_CFG: tmr_load = LOGIC_CFG_CYC[31:0];
      BCI_ST_INIT: tmr_load = INIT_CYC[31:0]; // see [R20]
      default: tmr_load = BUS_CFG_CYC[31:0];
    endcase
  end

  bci_step_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(step_start),
    .load_val(tmr_load),
    .expired_q(tmr_exp)
  );

  // Sequencer state and arming
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= BCI_ST_CFG_LOAD;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (hr_s2_q) begin
        armed_q <= 1'b0;
      end else if (step_start) begin
        armed_q <= 1'b1;
      end else if (adv) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ROM loader step requests
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_step_q <= BCI_STEP_BUS_CFG;
      rom_go_q <= 1'b0;
      init_busy_q <= 1'b1;
    end else begin
      rom_go_q <= step_start; // see [R21]
      init_busy_q <= (state_d != BCI_ST_READY);
      // Host reset shows the first step at once, not the stale last one
      if (hr_s2_q) begin
        rom_step_q <= BCI_STEP_BUS_CFG; // see [R22]
      end else if (step_start) begin
        case (state_d)
          BCI_ST_LOGIC_CFG: rom_step_q <= BCI_STEP_LOGIC_CFG;
          BCI_ST_INIT: rom_step_q <= BCI_STEP_INIT;
          default: rom_step_q <= BCI_STEP_BUS_CFG;
        endcase
      end
    end
  end

  // Control register; hardware sets win over software clears
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `BCI_RESET_VAL; // see [R23]
    end else if (step_start && (state_d == BCI_ST_INIT)) begin
      // Defaults invoked at init start, with the request raised
      ctrl_q <= `BCI_RESET_VAL; // see [R21] see [R23]
      ctrl_q[`BCI_INIT] <= (state_q == BCI_ST_READY);
    end else begin
      // Plain fields written only once the sequence is done
      if (wr_hit) begin
        ctrl_q <= (bus_wdata & `BCI_PLAIN_MASK) |
                  (ctrl_q & ~`BCI_PLAIN_MASK); // see [R01] see [R02]
        ctrl_q[`BCI_CALM_MSB:`BCI_CALM_LSB] <=
          bus_wdata[`BCI_CALM_MSB:`BCI_CALM_LSB]; // see [R13]
      end
      ctrl_q[`BCI_EMPTY] <= 1'b0;
      ctrl_q[`BCI_HALF] <= 1'b0;
      ctrl_q[`BCI_FULL] <= 1'b0;
      // Calibration result and automatic return to normal mode
      if (cal_done) begin
        ctrl_q[`BCI_CALFAIL] <= cal_fail; // see [R03]
        if (!(wr_hit &&
            (bus_wdata[`BCI_CALM_MSB:`BCI_CALM_LSB] != 2'h0))) begin
          ctrl_q[`BCI_CALM_MSB:`BCI_CALM_LSB] <= 2'h0; // see [R13] see [R16]
        end
      end
      // Request flag: event beats a same-cycle software clear
      if (irq_set) begin
        ctrl_q[`BCI_IRQFLAG] <= 1'b1; // see [R12]
      end else if (wr_hit && !bus_wdata[`BCI_IRQFLAG]) begin
        ctrl_q[`BCI_IRQFLAG] <= 1'b0; // see [R12]
      end
      // Software strobe; a write while one is pending starts no new strobe pulse
      if (wr_hit && bus_wdata[`BCI_STROBE]) begin
        ctrl_q[`BCI_STROBE] <= 1'b1; // see [R14]
      end else if (strobe_done) begin
        ctrl_q[`BCI_STROBE] <= 1'b0; // see [R14] see [R16]
      end
      // Trigger accepted only in a burst mode
      if (wr_hit && bus_wdata[`BCI_TRIG] &&
          is_burst(ctrl_q[`BCI_MODE_MSB:`BCI_MODE_LSB])) begin
        ctrl_q[`BCI_TRIG] <= 1'b1; // see [R15]
      end else if (conv_done) begin
        ctrl_q[`BCI_TRIG] <= 1'b0; // see [R15] see [R16]
      end
      // Init bit drops when the init step ends
      if ((state_q == BCI_ST_INIT) && adv) begin
        ctrl_q[`BCI_INIT] <= 1'b0; // see [R20] see [R16]
      end
    end
  end

  // Command pulses on the rising edge of the strobe and trigger bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_go_q <= 1'b0;
      conv_go_q <= 1'b0;
    end else begin
      strobe_go_q <= wr_hit && bus_wdata[`BCI_STROBE] &&
                     !ctrl_q[`BCI_STROBE]; // see [R14]
      conv_go_q <= wr_hit && bus_wdata[`BCI_TRIG] && !ctrl_q[`BCI_TRIG] &&
                   is_burst(ctrl_q[`BCI_MODE_MSB:`BCI_MODE_LSB]); // see [R15]
    end
  end

  // Status bits come live from the buffer
  always_comb begin
    rd_val = ctrl_q;
    rd_val[`BCI_EMPTY] = buf_empty; // see [R10]
    rd_val[`BCI_HALF] = buf_half;
    rd_val[`BCI_FULL] = buf_full;
  end

  // Bus answer one cycle after the strobe; retry until bus config loads
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ack_q <= 1'b0;
      bus_retry_q <= 1'b0;
      bus_rdata_q <= 32'h0000_0000;
    end else begin
      bus_ack_q <= 1'b0;
      bus_retry_q <= 1'b0;
      if (bus_req && (hr_s2_q || (state_q == BCI_ST_CFG_LOAD))) begin
        bus_retry_q <= 1'b1; // see [R22]
      end else if (reg_hit) begin
        bus_ack_q <= 1'b1; // see [R24]
        bus_rdata_q <= bus_wr ? bus_rdata_q : rd_val;
      end
    end
  end

  // Bus interrupt enable is forced off while configuring
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_irq_en_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      if (hr_s2_q || (state_q == BCI_ST_CFG_LOAD) ||
          (state_q == BCI_ST_LOGIC_CFG)) begin
        bus_irq_en_q <= 1'b0; // see [R18]
      end else if (bus_irq_en_set) begin
        bus_irq_en_q <= 1'b1;
      end else if (bus_irq_en_clr) begin
        bus_irq_en_q <= 1'b0;
      end
      irq_req_q <= ctrl_q[`BCI_IRQFLAG] && bus_irq_en_q; // see [R12]
    end
  end

  // Buffer held empty by software or through init
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_flush_q <= 1'b1;
      burst_mode_q <= 1'b1;
    end else begin
      buf_flush_q <= ctrl_q[`BCI_BUFCLR] ||
                     (state_q != BCI_ST_READY); // see [R06] see [R21]
      burst_mode_q <= is_burst(ctrl_q[`BCI_MODE_MSB:`BCI_MODE_LSB]);
    end
  end

  // Field outputs taken straight from the register flops
  assign input_mode_sel_q = ctrl_q[`BCI_MODE_MSB:`BCI_MODE_LSB];
  assign loopback_chan_q = ctrl_q[`BCI_LOOP_MSB:`BCI_LOOP_LSB];
  assign offset_binary_q = ctrl_q[`BCI_OFSBIN]; // see [R04]
  assign buffer_depth_q = ctrl_q[`BCI_DEPTH_MSB:`BCI_DEPTH_LSB]; // see [R05]
  assign active_chan_count_q = ctrl_q[`BCI_CHCNT_MSB:`BCI_CHCNT_LSB]; // see [R07]
  assign out_enable_q = ctrl_q[`BCI_OUTEN]; // see [R08]
  assign out_strobe_en_q = ctrl_q[`BCI_STBEN]; // see [R09]
  assign irq_source_sel_q = ctrl_q[`BCI_IRQSEL_MSB:`BCI_IRQSEL_LSB];
  assign calib_mode_q = ctrl_q[`BCI_CALM_MSB:`BCI_CALM_LSB];

endmodule

// file: bci_board_ctrl_checker.sv
// Port-level assertions for the board control block
`timescale 1ns/10ps
module bci_board_ctrl_checker
  import bci_pkg::*;
#(
  parameter int unsigned BUS_CFG_CYC = 20,
  parameter int unsigned LOGIC_CFG_CYC = 40,
  parameter int unsigned INIT_CYC = 20
)
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic host_rst_in, // Host bus reset
  input wire logic bus_req, // Access strobe
  input wire logic bus_wr, // Write flag
  input wire logic [4:0] bus_addr, // Offset
  input wire logic [31:0] bus_wdata, // Write data
  input wire logic bus_ack_q, // Done
  input wire logic bus_retry_q, // Retry
  input wire logic bus_irq_en_set, // Enable pulse
  input wire logic [2:0] input_mode_sel_q, // Mode
  input wire logic burst_mode_q, // Burst
  input wire logic buf_flush_q, // Flush
  input wire logic strobe_go_q, // Strobe pulse
  input wire logic conv_go_q, // Conversion pulse
  input wire logic [1:0] rom_step_q, // Step
  input wire logic rom_go_q, // Step start
  input wire logic init_busy_q, // Busy
  input wire logic bus_irq_en_q, // Irq enable
  input wire logic irq_req_q // Request
);
  // Slack covers the reset synchroniser and step hand-over cycles
  localparam int unsigned BUSY_MAX =
    BUS_CFG_CYC + LOGIC_CFG_CYC + INIT_CYC + 8;
  logic [31:0] busy_cnt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Length of the current busy stretch; host reset restarts it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= 32'h0;
    end else if (host_rst_in) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= init_busy_q ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end

  sequence s_ready_wr;
    bus_req && bus_wr && !init_busy_q && bus_addr == 5'h00 &&
    !$past(host_rst_in, 2);
  endsequence
  sequence s_init_wr;
    s_ready_wr ##0 bus_wdata[31];
  endsequence

  chk_answer_once: assert property (bus_req && bus_addr == 5'h00 |=>
    bus_ack_q != bus_retry_q) else $error("not one answer");
  chk_retry_cfg: assert property (bus_retry_q |->
    ($past(rom_step_q) == 2'h0 && $past(init_busy_q)) ||
    $past(host_rst_in, 3)) else $error("retry outside bus load");
  chk_ready_ack: assert property (s_ready_wr |=> bus_ack_q)
    else $error("ready write not acked");
  chk_strobe_src: assert property (strobe_go_q |->
    $past(bus_req && bus_wr && bus_wdata[29]) ##1 !strobe_go_q)
    else $error("strobe pulse wrong");
  chk_conv_burst: assert property (conv_go_q |->
    $past(input_mode_sel_q inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h7} &&
    bus_req && bus_wr && bus_wdata[30]))
    else $error("trigger outside burst");
  chk_burst_decode: assert property ($stable(input_mode_sel_q) |->
    burst_mode_q == (input_mode_sel_q inside {3'h1, 3'h3, 3'h4, 3'h5,
    3'h7})) else $error("burst decode wrong");
  chk_flush_busy: assert property ($past(init_busy_q) |-> buf_flush_q)
    else $error("buffer not flushed in init");
  chk_init_start: assert property (s_init_wr |=>
    rom_go_q && rom_step_q == 2'h2 && init_busy_q)
    else $error("reinit did not start");
  chk_busy_bound: assert property (busy_cnt_q <= BUSY_MAX)
    else $error("sequence too long");
  chk_step_order: assert property ($changed(rom_step_q) &&
    rom_step_q == 2'h1 |-> $past(rom_step_q) == 2'h0)
    else $error("step order wrong");
  chk_irq_gate: assert property (irq_req_q |-> $past(bus_irq_en_q))
    else $error("request while disabled");
  chk_irq_en_src: assert property ($rose(bus_irq_en_q) |->
    $past(bus_irq_en_set)) else $error("irq enabled by itself");
endmodule

bind bci_board_ctrl bci_board_ctrl_checker #(.BUS_CFG_CYC(BUS_CFG_CYC),
  .LOGIC_CFG_CYC(LOGIC_CFG_CYC), .INIT_CYC(INIT_CYC)) i_chk (.*);

// file: bci_far_model.sv
// Far side model: ROM loader, strobe, converter and calibrator
`timescale 1ns/10ps
module bci_far_model (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic rom_go_q, // Step start
  input wire logic strobe_go_q, // Strobe start
  input wire logic conv_go_q, // Conversion start
  input wire logic [1:0] calib_mode_q, // Calibration request
  input wire logic [7:0] dly, // Answer delay, 2 or more
  input wire logic slow, // Leave ROM steps to time out
  input wire logic fail_in, // Calibration result
  output logic step_done, // Step finished
  output logic strobe_done, // Strobe finished
  output logic conv_done, // Conversion finished
  output logic cal_done, // Calibration finished
  output logic cal_fail // Result beside cal_done
);
  logic [7:0] cnt_q;
  logic [3:0] job_q;
  logic [3:0] start;

  assign start = {|calib_mode_q, conv_go_q, strobe_go_q, rom_go_q & ~slow};

  // One job at a time; starts seen while busy are dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      job_q <= 4'h0;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      job_q <= start;
      cnt_q <= (start != 4'h0) ? dly : 8'h00;
    end
  end

  // Completion pulses that let the command bits drop
  assign step_done = (cnt_q == 8'h01) && job_q[0];
  assign strobe_done = (cnt_q == 8'h01) && job_q[1];
  assign conv_done = (cnt_q == 8'h01) && job_q[2];
  assign cal_done = (cnt_q == 8'h01) && job_q[3];
  assign cal_fail = fail_in;
endmodule

// file: tb_top.sv
// Self-checking bench for the board control register block
`timescale 1ns/10ps
`include "bci_defs.svh"
module tb_top;
  import bci_pkg::*;
  typedef struct {logic rt; logic rd; logic [31:0] d;} bci_exp_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic host_rst_in = 1'b0;
  logic bus_req = 1'b0;
  logic bus_wr = 1'b0;
  logic [4:0] bus_addr = 5'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_irq_en_set = 1'b0;
  logic bus_irq_en_clr = 1'b0;
  logic [7:0] irq_cond = 8'h00;
  logic buf_empty = 1'b1;
  logic buf_half = 1'b0;
  logic buf_full = 1'b0;
  logic [7:0] dly = 8'h08;
  logic slow = 1'b0;
  logic fail_in = 1'b1;
  logic [31:0] bus_rdata_q;
  logic bus_ack_q, bus_retry_q, buf_flush_q, offset_binary_q, out_enable_q;
  logic out_strobe_en_q, burst_mode_q, strobe_go_q, conv_go_q, rom_go_q;
  logic init_busy_q, bus_irq_en_q, irq_req_q;
  logic [2:0] input_mode_sel_q, active_chan_count_q, irq_source_sel_q;
  logic [1:0] loopback_chan_q, calib_mode_q, rom_step_q;
  logic [3:0] buffer_depth_q;
  logic step_done, strobe_done, conv_done, cal_done, cal_fail;
  bci_exp_t exp_q[$];
  bci_exp_t ex;
  integer seed;
  logic [31:0] w, e;
  int miscompares = 0;
  int check_count = 0;

  bci_board_ctrl #(.BUS_CFG_CYC(20), .LOGIC_CFG_CYC(40), .INIT_CYC(20))
    i_dut (.*);
  bci_far_model i_far (.*);

  // Clock
  always #2.5 clk = ~clk;

  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", n, x, g);
      miscompares++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One access; the expected answer is noted before the request goes out
  task automatic acc(logic wr, logic [4:0] a, logic [31:0] d, logic rt,
      logic [31:0] x);
    if (a == 5'h00 || rt) exp_q.push_back('{rt, !wr && !rt, x});
    @(negedge clk);
    bus_req = 1'b1;
    bus_wr = wr;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    bus_req = 1'b0;
  endtask

  task automatic wrt(logic [31:0] d);
    acc(1'b1, 5'h00, d, 1'b0, 32'h0);
  endtask

  task automatic rd(logic [31:0] x);
    acc(1'b0, 5'h00, 32'h0, 1'b0, x);
  endtask

  task automatic wait_ready();
    int n = 0;
    while ((init_busy_q !== 1'b0 || exp_q.size() != 0) && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic pulse_irq(logic [7:0] c);
    @(negedge clk);
    irq_cond = c;
    @(negedge clk);
    irq_cond = 8'h00;
  endtask

  function automatic logic [31:0] live();
    return {9'h0, buf_full, buf_half, buf_empty, 20'h0};
  endfunction

  // Answer watcher: each answer takes the oldest note
  always @(negedge clk) begin
    if (bus_ack_q === 1'b1 || bus_retry_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected answer", 32'h0, 32'h1);
      end else begin
        ex = exp_q.pop_front();
        chk("retry", {31'h0, ex.rt}, {31'h0, bus_retry_q});
        if (ex.rd) chk("read data", ex.d, bus_rdata_q);
      end
    end
  end

  initial begin
    seed = 32'h5E32;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    acc(1'b0, 5'h00, 32'h0, 1'b1, 32'h0);
    wait_ready();
    chk("irq enable", 32'h0, {31'h0, bus_irq_en_q});
    rd(`BCI_RESET_VAL);
    $display("test powerup done");
    for (int i = 0; i < 8; i++) begin
      w = $random(seed) & 32'h03FFFFFF;
      w[2:0] = i[2:0];
      {buf_full, buf_half, buf_empty} = 3'($random(seed));
      wrt(w);
      rd((w & `BCI_PLAIN_MASK) | live());
      chk("burst", {31'h0, i inside {1, 3, 4, 5, 7}}, {31'h0, burst_mode_q});
      chk("fields", {16'h0, w[25:23], w[19:15], w[11:6], w[4:3]},
        {16'h0, irq_source_sel_q, out_strobe_en_q, out_enable_q,
        active_chan_count_q, buf_flush_q, buffer_depth_q, offset_binary_q,
        loopback_chan_q});
    end
    e = (w & `BCI_PLAIN_MASK) | live();
    acc(1'b0, 5'h04, 32'h0, 1'b0, 32'h0);
    acc(1'b1, 5'h08, 32'hFFFFFFFF, 1'b0, 32'h0);
    rd(e);
    $display("test fields done");
    bus_irq_en_set = 1'b1;
    @(negedge clk);
    bus_irq_en_set = 1'b0;
    pulse_irq(~(8'h01 << w[25:23]));
    rd(e);
    pulse_irq(8'h01 << w[25:23]);
    rd(e | 32'h04000000);
    chk("irq req", 32'h1, {31'h0, irq_req_q});
    wrt(w);
    rd(e);
    chk("irq req", 32'h0, {31'h0, irq_req_q});
    pulse_irq(8'h01 << w[25:23]);
    bus_irq_en_clr = 1'b1;
    @(negedge clk);
    bus_irq_en_clr = 1'b0;
    @(negedge clk);
    chk("irq off", 32'h0, {31'h0, irq_req_q});
    chk("irq enable", 32'h0, {31'h0, bus_irq_en_q});
    $display("test irq done");
    wrt(w | 32'h20000000);
    rd(e | 32'h20000000);
    repeat (12) @(negedge clk);
    rd(e);
    wrt(w | 32'h40000000);
    rd(e | 32'h40000000);
    repeat (12) @(negedge clk);
    rd(e);
    w[2:0] = 3'h0;
    e[2:0] = 3'h0;
    wrt(w);
    wrt(w | 32'h40000000);
    rd(e);
    wrt(w | 32'h08000000);
    repeat (15) @(negedge clk);
    rd(e | 32'h00000020);
    $display("test commands done");
    {buf_full, buf_half, buf_empty} = 3'h1;
    slow = 1'b1;
    wrt(w | 32'h80000000);
    rd(`BCI_RESET_VAL | 32'h80000000);
    chk("flush", 32'h1, {31'h0, buf_flush_q});
    wait_ready();
    rd(`BCI_RESET_VAL);
    $display("test reinit done");
    host_rst_in = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b0, 5'h10, 32'h0, 1'b1, 32'h0);
    host_rst_in = 1'b0;
    wait_ready();
    chk("irq enable", 32'h0, {31'h0, bus_irq_en_q});
    rd(`BCI_RESET_VAL);
    wait_ready();
    $display("test host reset done");
    report_and_stop();
  end
endmodule
